/* File: pkg/hsba_pkg.sv */
/*
  Shared constants and bundles for the system bus agent: pin bundles,
  user-side request and snoop records, response encodings and one-hot states.
  Assumes a single core clock and that all pin values are electrical levels.
*/
package hsba_pkg;

  // ----------------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 33;          // Address lines 35:3.
  localparam int CMD_W = 5;            // Request command lines.
  localparam int GRP_N = 4;            // Data strobe groups.
  localparam int GRP_W = 16;           // Data bits per group.
  localparam int BEATS = 4;            // Quad-pumped beats per transfer.
  localparam int DATA_W = GRP_N * GRP_W;

  // ----------------------------------------------------------------------
  // Response codes (logical values)
  // ----------------------------------------------------------------------
  localparam logic [2:0] RESP_IDLE = 3'h0;
  localparam logic [2:0] RESP_RETRY = 3'h1;
  localparam logic [2:0] RESP_DEFER = 3'h2;
  localparam logic [2:0] RESP_RSVD = 3'h3;
  localparam logic [2:0] RESP_HARDFAIL = 3'h4;
  localparam logic [2:0] RESP_NODATA = 3'h5;
  localparam logic [2:0] RESP_IWB = 3'h6;
  localparam logic [2:0] RESP_NORMAL = 3'h7;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] RESP_RST = 3'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Electrical levels of every input pin, sampled as one bundle.
  typedef struct packed {
    logic clkPos;
    logic clkNeg;
    logic reqStrobeN;
    logic lockN;
    logic cleanHitN;
    logic dirtyHitN;
    logic [1:0] addrStrobeN;
    logic [ADDR_W-1:0] addrN;
    logic [CMD_W-1:0] cmdN;
    logic [GRP_N-1:0] strobeTrueN;
    logic [GRP_N-1:0] strobeCompN;
    logic [GRP_N-1:0] invertN;
    logic [DATA_W-1:0] dataN;
  } hsba_pins_t;

  // A captured processor request (logical values).
  typedef struct packed {
    logic valid;
    logic locked;
    logic [ADDR_W-1:0] addr;
    logic [CMD_W-1:0] cmdA;
    logic [CMD_W-1:0] cmdB;
  } hsba_req_t;

  // Snoop outcome seen on the hit lines.
  typedef struct packed {
    logic valid;
    logic clean;
    logic dirty;
  } hsba_snoop_t;

  // Snoop cycle that the block issues for an internal initiator.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CMD_W-1:0] cmdA;
    logic [CMD_W-1:0] cmdB;
  } hsba_issue_t;

  typedef enum logic [2:0] {
    ISS_IDLE = 3'h1,
    ISS_HALF_A = 3'h2,
    ISS_HALF_B = 3'h4
  } hsba_iss_t;

endpackage : hsba_pkg

/* File: hw/hsba_agent.sv */
/*
  Response and target agent for a multiprocessor system bus: captures requests,
  issues snoop cycles, watches snoop results and lock, captures quad-pumped data,
  and drives target ready, response code and response parity.
  Assumes every pin input is asynchronous to clk and that the far side keeps its
  own strobe and inversion duties; two-way pins are split into in, out and oe.
*/
// Overview of operation
// - Capture address lines during processor requests.
// - Drive address lines when issuing snoop cycles.
// - Address strobes drive and latch at 2x; issued snoop cycles here hold each half for one host clock.
// - Four strobe pairs latch data and flags.
// - Clean hit means unmodified copy held.
// - Dirty hit means modified copy, owner supplies.
// - Both hits together mean snoop stall.
// - Lock with request strobe starts atomic sequence.
// - Command lines carry two halves per request.
// - Target ready only when data phase possible.
// - Response codes encoded as listed.
// - Never drive reserved or hard failure codes.
// - Response parity driven valid every clock.
// - Response plus parity lows are even.
// - Logic timed from differential host clock.
// - Request strobe marks first request cycle.
// - Inversion flags keep lows at most eight.
// - Active-low lines carry inverted logical values.
module hsba_agent (
  input wire logic clk,
  input wire logic rst,
  input wire hsba_pkg::hsba_pins_t pinsIn,
  output logic [hsba_pkg::ADDR_W-1:0] addrOutN,
  output logic addrOe,
  output logic [hsba_pkg::CMD_W-1:0] cmdOutN,
  output logic cmdOe,
  output logic [1:0] addrStrobeOutN,
  output logic addrStrobeOe,
  output logic reqStrobeOutN,
  output logic reqStrobeOe,
  output logic targetReadyOutN,
  output logic [2:0] responseCodeN,
  output logic responseParityBitN,
  input wire logic issueReq,
  input wire hsba_pkg::hsba_issue_t issueCmd,
  output logic issueBusy,
  input wire logic dataPhaseOk,
  input wire logic respValid,
  input wire logic [2:0] respCode,
  output hsba_pkg::hsba_req_t reqOut,
  output hsba_pkg::hsba_snoop_t snoopOut,
  output logic atomicActive,
  output logic dataValid,
  output logic [hsba_pkg::DATA_W*hsba_pkg::BEATS-1:0] dataOut
);
  import hsba_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  hsba_pins_t syncA_q;   // First stage; read only by the second stage.
  hsba_pins_t syncB_q;   // Second stage; safe for logic.
  hsba_pins_t prev_q;    // One cycle older, for edge detection.

  // Every pin crosses two flops, since none is timed to clk.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_q <= '1;
      syncB_q <= '1;
      prev_q <= '1;
    end else begin
      syncA_q <= pinsIn;
      syncB_q <= syncA_q;
      prev_q <= syncB_q;
    end
  end

  // ----------------------------------------------------------------------
  // Host clock edge and request phase decode
  // ----------------------------------------------------------------------
  // The differential pair counts as high only when both legs agree.
  wire hostClkNow = syncB_q.clkPos & ~syncB_q.clkNeg;
  wire hostClkOld = prev_q.clkPos & ~prev_q.clkNeg;
  wire hostTick = hostClkNow & ~hostClkOld;
  wire driving = addrOe;
  // Logical values are the inverse of pin levels.
  wire reqStrobe = ~syncB_q.reqStrobeN;
  wire lockAsserted = ~syncB_q.lockN;
  wire cleanHit = ~syncB_q.cleanHitN;
  wire dirtyHit = ~syncB_q.dirtyHitN;
  wire snoopStall = cleanHit & dirtyHit;
  // A new request starts on the host edge where the strobe is asserted.
  wire reqStart = hostTick & reqStrobe & ~driving;
  // Both edges of address strobe 0 latch a half; the captured pair is 2x.
  wire aStbFall = prev_q.addrStrobeN[0] & ~syncB_q.addrStrobeN[0];
  wire aStbRise = ~prev_q.addrStrobeN[0] & syncB_q.addrStrobeN[0];

  // ----------------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------------
  logic reqOpen_q;           // Between request strobe and second half.
  hsba_req_t req_q;
  logic lock_q;              // Atomic sequence in progress.

  // First strobe edge takes address and first command half, second takes the rest.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reqOpen_q <= 1'b0;
      req_q <= '0;
    end else begin
      req_q.valid <= 1'b0;
      if (reqStart) begin
        reqOpen_q <= 1'b1;
      end else if (reqOpen_q && aStbFall) begin
        req_q.addr <= ~syncB_q.addrN;
        req_q.cmdA <= ~syncB_q.cmdN;
      end else if (reqOpen_q && aStbRise) begin
        req_q.cmdB <= ~syncB_q.cmdN;
        req_q.locked <= lock_q | lockAsserted;
        req_q.valid <= 1'b1;
        reqOpen_q <= 1'b0;
      end
    end
  end

  // Lock taken with the request strobe holds until lock is negated.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (reqStart && lockAsserted) begin
      lock_q <= 1'b1;
    end else if (!lockAsserted) begin
      lock_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Snoop result watch
  // ----------------------------------------------------------------------
  logic snoopWait_q;
  hsba_snoop_t snoop_q;

  // A stall combination keeps the window open; anything else is the result.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snoopWait_q <= 1'b0;
      snoop_q <= '0;
    end else begin
      snoop_q.valid <= 1'b0;
      if (req_q.valid) begin
        snoopWait_q <= 1'b1;
      end else if (snoopWait_q && hostTick && !snoopStall) begin
        snoop_q.valid <= 1'b1;
        snoop_q.clean <= cleanHit;
        snoop_q.dirty <= dirtyHit;
        snoopWait_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Snoop cycle issue
  // ----------------------------------------------------------------------
  hsba_iss_t iss_q, iss_d;
  hsba_issue_t issCmd_q;
  // Only start when nobody else is mid request.
  wire issueGo = issueReq & ~reqOpen_q & ~reqStrobe;
  // While idle the live command drives the pins, so a start on the latching edge is not stale.
  wire hsba_issue_t issNow = (iss_q == ISS_IDLE) ? issueCmd : issCmd_q;

  // Each half lasts one host clock; the strobe toggles between halves.
  always_comb begin
    iss_d = iss_q;
    case (iss_q)
      ISS_IDLE: begin
        if (issueGo && hostTick) iss_d = ISS_HALF_A;
      end
      ISS_HALF_A: begin
        if (hostTick) iss_d = ISS_HALF_B;
      end
      ISS_HALF_B: begin
        if (hostTick) iss_d = ISS_IDLE;
      end
      default: iss_d = ISS_IDLE;
    endcase
  end

  // Pin drive follows the next state so every output is a flop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      iss_q <= ISS_IDLE;
      issCmd_q <= '0;
      addrOutN <= '1;
      addrOe <= 1'b0;
      cmdOutN <= '1;
      cmdOe <= 1'b0;
      addrStrobeOutN <= 2'h3;
      addrStrobeOe <= 1'b0;
      reqStrobeOutN <= 1'b1;
      reqStrobeOe <= 1'b0;
    end else begin
      iss_q <= iss_d;
      if (iss_q == ISS_IDLE && issueGo) issCmd_q <= issueCmd;
      addrOe <= (iss_d != ISS_IDLE);
      cmdOe <= (iss_d != ISS_IDLE);
      addrStrobeOe <= (iss_d != ISS_IDLE);
      reqStrobeOe <= (iss_d != ISS_IDLE);
      reqStrobeOutN <= ~(iss_d == ISS_HALF_A);
      addrStrobeOutN <= (iss_d == ISS_HALF_A) ? 2'h0 : 2'h3;
      addrOutN <= (iss_d != ISS_IDLE) ? ~issNow.addr : '1;
      if (iss_d == ISS_HALF_A) begin
        cmdOutN <= ~issNow.cmdA;
      end else if (iss_d == ISS_HALF_B) begin
        cmdOutN <= ~issCmd_q.cmdB;
      end else begin
        cmdOutN <= '1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Quad-pumped data capture, one generate lane per strobe pair
  // ----------------------------------------------------------------------
  wire [GRP_N-1:0] laneDone;
  wire [DATA_W*BEATS-1:0] beatsAll;  // All four beats, gathered from the lanes.
  logic xferDone_q;                   // Last beat of the top group has landed.

  for (genvar g = 0; g < GRP_N; g++) begin : gLane
    logic [1:0] beat_q;
    logic [GRP_W-1:0] slot_q [BEATS];  // This group's word for each beat.
    // A falling edge on either leg of the pair marks one beat.
    wire tEdge = prev_q.strobeTrueN[g] & ~syncB_q.strobeTrueN[g];
    wire cEdge = prev_q.strobeCompN[g] & ~syncB_q.strobeCompN[g];
    wire beatHit = (tEdge | cEdge) & ~driving;
    wire [GRP_W-1:0] raw = ~syncB_q.dataN[g*GRP_W +: GRP_W];
    // An asserted flag means the sender inverted this group to limit lows.
    wire [GRP_W-1:0] word = ~syncB_q.invertN[g] ? ~raw : raw;
    assign laneDone[g] = beatHit & (beat_q == 2'(BEATS - 1));

    // Beat slot and word store for this group; each lane owns its own array.
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        beat_q <= 2'h0;
        slot_q <= '{default: '0};
      end else if (beatHit) begin
        beat_q <= beat_q + 2'h1;
        slot_q[beat_q] <= word;
      end
    end
    for (genvar b = 0; b < BEATS; b++) begin : gBeat
      assign beatsAll[b*DATA_W + g*GRP_W +: GRP_W] = slot_q[b];
    end
  end

  // The copy waits one clock after the last beat, so that beat is already in the store.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xferDone_q <= 1'b0;
      dataValid <= 1'b0;
      dataOut <= '0;
    end else begin
      xferDone_q <= laneDone[GRP_N-1];
      dataValid <= xferDone_q;
      if (xferDone_q) dataOut <= beatsAll;
    end
  end

  // ----------------------------------------------------------------------
  // Target ready, response and parity
  // ----------------------------------------------------------------------
  // Reserved and hard failure are mapped to idle rather than ever reaching the pins.
  wire badCode = (respCode == RESP_RSVD) | (respCode == RESP_HARDFAIL);
  wire [2:0] respSel = (respValid && !badCode) ? respCode : RESP_IDLE;

  // Parity flop updates every clock, so it is valid even between responses.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      targetReadyOutN <= 1'b1;
      responseCodeN <= ~RESP_RST;
      responseParityBitN <= ~(^RESP_RST);
    end else begin
      targetReadyOutN <= ~dataPhaseOk;
      responseCodeN <= ~respSel;
      responseParityBitN <= ~(^respSel);
    end
  end

  // ----------------------------------------------------------------------
  // User-side status
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reqOut <= '0;
      snoopOut <= '0;
      atomicActive <= 1'b0;
      issueBusy <= 1'b0;
    end else begin
      reqOut <= req_q;
      snoopOut <= snoop_q;
      atomicActive <= lock_q;
      issueBusy <= (iss_d != ISS_IDLE) | (iss_q != ISS_IDLE);
    end
  end

endmodule : hsba_agent

/* File: sim/hsba_agent_sva.sv */
/*
  Concurrent checks on the ports of the system bus agent, bound to each instance.
  Assumes one clock domain, clk rising edge, and rst active high.
*/
module hsba_agent_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [hsba_pkg::ADDR_W-1:0] addrOutN,
  input wire logic addrOe,
  input wire logic cmdOe,
  input wire logic [1:0] addrStrobeOutN,
  input wire logic addrStrobeOe,
  input wire logic reqStrobeOutN,
  input wire logic targetReadyOutN,
  input wire logic [2:0] responseCodeN,
  input wire logic responseParityBitN,
  input wire logic dataPhaseOk,
  input wire logic respValid,
  input wire logic [2:0] respCode,
  input wire hsba_pkg::hsba_req_t reqOut,
  input wire hsba_pkg::hsba_snoop_t snoopOut,
  input wire logic dataValid
);
  timeunit 1ns;
  timeprecision 1ns;
  import hsba_pkg::*;
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cbk @(posedge clk); endclocking
  default disable iff (rst);
  resp_map_a: assert property (!$past(rst) && respValid && respCode != RESP_RSVD &&
    respCode != RESP_HARDFAIL |=> responseCodeN == ~$past(respCode)) else $error("bad code");
  code_legal_a: assert property (~responseCodeN != RESP_RSVD &&
    ~responseCodeN != RESP_HARDFAIL) else $error("forbidden response code");
  parity_even_a: assert property (^{responseCodeN, responseParityBitN} == 1'b0)
    else $error("odd lows on response");
  ready_follow_a: assert property (!$past(rst) |->
    targetReadyOutN == !$past(dataPhaseOk)) else $error("target ready wrong");
  issue_start_a: assert property ($rose(addrOe) |-> cmdOe && !reqStrobeOutN &&
    addrStrobeOutN == 2'b00) else $error("issue start wrong");
  addr_hold_a: assert property (addrOe && $past(addrOe) |-> $stable(addrOutN))
    else $error("address moved while driven");
  strobe_pair_a: assert property (addrStrobeOe |-> addrStrobeOutN[0] == addrStrobeOutN[1])
    else $error("strobes differ");
  req_pulse_a: assert property (reqOut.valid |=> !reqOut.valid) else $error("request pulse");
  snoop_stall_a: assert property (snoopOut.valid |-> !(snoopOut.clean && snoopOut.dirty))
    else $error("stall reported as hit");
  data_pulse_a: assert property (dataValid |=> !dataValid) else $error("data pulse");
  // Coverage of the main transfers.
  cover property (snoopOut.valid && snoopOut.dirty);
  cover property ($rose(addrOe));
  cover property (dataValid);
endmodule : hsba_agent_sva

bind hsba_agent hsba_agent_sva chk (.clk, .rst, .addrOutN, .addrOe, .cmdOe, .addrStrobeOutN,
  .addrStrobeOe, .reqStrobeOutN, .targetReadyOutN, .responseCodeN, .responseParityBitN,
  .dataPhaseOk, .respValid, .respCode, .reqOut, .snoopOut, .dataValid);

/* File: sim/hsba_proc_model.sv */
/*
  Behavioural processor on the far side: host clock, requests, snoop hits,
  data bursts, and a latch for snoop cycles that the agent issues.
  Assumes the bench wire-ANDs its drive with the agent's and that lines idle high.
*/
module hsba_proc_model (
  output hsba_pkg::hsba_pins_t drv,
  input wire logic [hsba_pkg::ADDR_W-1:0] busAddrN,
  input wire logic [hsba_pkg::CMD_W-1:0] busCmdN,
  input wire logic busStrobeN,
  output hsba_pkg::hsba_issue_t seen
);
  timeunit 1ns;
  timeprecision 1ns;
  import hsba_pkg::*;
  // ----------------------------------------------------------------------
  // Host clock, free running, unrelated in phase to clk
  // ----------------------------------------------------------------------
  initial begin
    drv = '1;  // Released lines float up to the termination level.
    drv.clkPos = 1'b0;
    drv.clkNeg = 1'b1;
    #23;
    forever begin
      #400 drv.clkPos = ~drv.clkPos;
      drv.clkNeg = ~drv.clkPos;  // Complement leg of the pair.
    end
  end
  // Request phase: strobe low across a host edge, then two strobed halves.
  task automatic request(input logic [ADDR_W-1:0] a, input logic [CMD_W-1:0] ca,
                         input logic [CMD_W-1:0] cb, input logic lk);
    @(negedge drv.clkPos);
    drv.reqStrobeN = 1'b0;
    drv.lockN = ~lk;
    @(posedge drv.clkPos);
    #200 drv.addrN = ~a;
    drv.cmdN = ~ca;  // First half carries the type.
    #200 drv.addrStrobeN = 2'b00;
    drv.reqStrobeN = 1'b1;
    #400 drv.cmdN = ~cb;
    #200 drv.addrStrobeN = 2'b11;
    #400 drv.addrN = '1;
    drv.cmdN = '1;
  endtask : request
  task automatic unlock();
    drv.lockN = 1'b1;
  endtask : unlock
  task automatic hits(input logic c, input logic d);
    drv.cleanHitN = ~c;
    drv.dirtyHitN = ~d;
  endtask : hits
  // Four beats, alternating strobe legs; inversion keeps lows at eight or fewer.
  task automatic burst(input logic [DATA_W*BEATS-1:0] d);
    logic [GRP_W-1:0] g16;
    for (int b = 0; b < BEATS; b++) begin
      for (int g = 0; g < GRP_N; g++) begin
        g16 = d[b*DATA_W+g*GRP_W +: GRP_W];
        drv.invertN[g] = ($countones(g16) <= 8);
        drv.dataN[g*GRP_W +: GRP_W] = drv.invertN[g] ? ~g16 : g16;
      end
      #200 drv.strobeTrueN = b[0] ? '1 : '0;
      drv.strobeCompN = b[0] ? '0 : '1;
      #200;
    end
    drv.strobeCompN = '1;
    drv.dataN = '1;
    drv.invertN = '1;
  endtask : burst
  // Latch issued snoop cycles just after each strobe edge.
  always @(negedge busStrobeN) begin
    #1 seen.addr = ~busAddrN;
    seen.cmdA = ~busCmdN;
  end
  always @(posedge busStrobeN) begin
    #1 seen.cmdB = ~busCmdN;
  end
endmodule : hsba_proc_model

/* File: sim/tb_hsba_agent.sv */
/*
  Self-checking bench for the system bus agent with a processor model.
  Assumes the checker is bound by its own file; seed for stimulus is 77.
*/
module tb_hsba_agent;
  timeunit 1ns;
  timeprecision 1ns;
  import hsba_pkg::*;
  logic clk = 1'b0, rst, addrOe, cmdOe, addrStrobeOe, reqStrobeOutN, reqStrobeOe;
  logic targetReadyOutN, responseParityBitN, issueReq, issueBusy, dataPhaseOk, respValid;
  logic atomicActive, dataValid, lk;
  logic [ADDR_W-1:0] addrOutN;
  logic [CMD_W-1:0] cmdOutN;
  logic [1:0] addrStrobeOutN;
  logic [2:0] responseCodeN, respCode;
  logic [31:0] seed;
  logic [DATA_W*BEATS-1:0] dataOut, dat;
  hsba_pins_t drv, pinsIn;
  hsba_issue_t issueCmd, seen, rq;
  hsba_req_t reqOut;
  hsba_snoop_t snoopOut;
  int err_count, n_tests, i, k;
  always #50 clk = ~clk;
  // Open-drain lines: each party pulls low, the wire is the AND.
  always_comb begin
    pinsIn = drv;
    pinsIn.addrN = drv.addrN & ((addrOe === 1'b1) ? addrOutN : '1);
    pinsIn.cmdN = drv.cmdN & ((cmdOe === 1'b1) ? cmdOutN : '1);
    pinsIn.addrStrobeN = drv.addrStrobeN & ((addrStrobeOe === 1'b1) ? addrStrobeOutN : 2'h3);
    pinsIn.reqStrobeN = drv.reqStrobeN & ((reqStrobeOe === 1'b1) ? reqStrobeOutN : 1'b1);
  end
  hsba_proc_model model (.drv(drv), .busAddrN(pinsIn.addrN), .busCmdN(pinsIn.cmdN),
    .busStrobeN(pinsIn.addrStrobeN[0]), .seen(seen));
  hsba_agent DUT (.clk(clk), .rst(rst), .pinsIn(pinsIn), .addrOutN(addrOutN), .addrOe(addrOe),
    .cmdOutN(cmdOutN), .cmdOe(cmdOe), .addrStrobeOutN(addrStrobeOutN),
    .addrStrobeOe(addrStrobeOe), .reqStrobeOutN(reqStrobeOutN), .reqStrobeOe(reqStrobeOe),
    .targetReadyOutN(targetReadyOutN), .responseCodeN(responseCodeN),
    .responseParityBitN(responseParityBitN), .issueReq(issueReq), .issueCmd(issueCmd),
    .issueBusy(issueBusy), .dataPhaseOk(dataPhaseOk), .respValid(respValid),
    .respCode(respCode), .reqOut(reqOut), .snoopOut(snoopOut), .atomicActive(atomicActive),
    .dataValid(dataValid), .dataOut(dataOut));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Forbidden codes fall back to idle.
  function automatic logic [2:0] expCode(input logic [2:0] c);
    return (c == RESP_RSVD || c == RESP_HARDFAIL) ? RESP_IDLE : c;
  endfunction : expCode
  task automatic check(input string what, input logic [255:0] got, input logic [255:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Watchdog: far beyond the roughly 40 us that the sequence needs.
  initial begin
    #1_000_000 err_count++;
    $display("watchdog expired");
    summarize();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'd77;
    {err_count, n_tests, issueReq, dataPhaseOk, respValid, respCode} = '0;
    issueCmd = '0;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // Every response code, with target ready toggling alongside.
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      {respValid, respCode, dataPhaseOk} = {1'b1, i[2:0], i[0]};
      @(negedge clk);
      respValid = 1'b0;
      check("responseCodeN", responseCodeN, 3'(~expCode(i[2:0])));
      check("responseParityBitN", responseParityBitN, ^(~expCode(i[2:0])));
      check("targetReadyOutN", targetReadyOutN, 1'(~i[0]));
    end
    @(negedge clk);
    check("responseCodeN", responseCodeN, 3'(~RESP_IDLE));
    $display("response test done");
    // Requests with a snoop stall first; the last two are locked.
    for (i = 0; i < 4; i++) begin
      rq = '{ADDR_W'({rnd(), rnd()}), 5'(rnd()), 5'(rnd())};
      lk = (i >= 2);
      model.hits(1'b1, 1'b1);
      fork
        model.request(rq.addr, rq.cmdA, rq.cmdB, lk);
      join_none
      for (k = 0; k < 80 && reqOut.valid !== 1'b1; k++) @(negedge clk);
      check("reqOut.valid", reqOut.valid, 1'b1);
      check("reqOut.addr", reqOut.addr, rq.addr);
      check("reqOut.cmd", {reqOut.cmdA, reqOut.cmdB}, {rq.cmdA, rq.cmdB});
      check("reqOut.locked", reqOut.locked, lk);
      repeat (12) @(negedge clk);
      model.hits(i % 3 == 0, i % 3 == 1);
      for (k = 0; k < 40 && snoopOut.valid !== 1'b1; k++) @(negedge clk);
      check("snoopOut", snoopOut, {1'b1, i % 3 == 0, i % 3 == 1});
      check("atomicActive", atomicActive, lk);
      model.hits(1'b0, 1'b0);
      repeat (8) @(negedge clk);
    end
    model.unlock();
    repeat (8) @(negedge clk);
    check("atomicActive", atomicActive, 1'b0);
    $display("request test done");
    // Snoop cycles issued by the agent.
    for (i = 0; i < 2; i++) begin
      issueCmd = '{ADDR_W'({rnd(), rnd()}), 5'(rnd()), 5'(rnd())};
      issueReq = 1'b1;
      for (k = 0; k < 40 && issueBusy !== 1'b1; k++) @(negedge clk);
      issueReq = 1'b0;
      for (k = 0; k < 60 && issueBusy !== 1'b0; k++) @(negedge clk);
      repeat (2) @(negedge clk);
      check("issued cycle", seen, issueCmd);
      check("addrOe", addrOe, 1'b0);
    end
    $display("issue test done");
    // Bursts: all ones, exactly eight ones per group, then random.
    for (i = 0; i < 4; i++) begin
      dat = (i == 0) ? '1 : {16{16'h0F0F}};
      for (k = 0; k < 8 && i > 1; k++) dat[k*32 +: 32] = rnd();
      fork
        model.burst(dat);
      join_none
      for (k = 0; k < 60 && dataValid !== 1'b1; k++) @(negedge clk);
      check("dataOut", dataOut, dat);
      repeat (6) @(negedge clk);
    end
    $display("data test done");
    summarize();
  end
endmodule : tb_hsba_agent
